/* File: hdl/twmc_pkg.sv */
package twmc_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL_A = 8'h80;
    localparam logic [7:0] OFS_CTRL_B = 8'h84;
    localparam logic [7:0] OFS_CMP_A  = 8'h88;
    localparam logic [7:0] OFS_CMP_B  = 8'h8c;
    localparam logic [7:0] OFS_CAPT   = 8'h90;
    localparam logic [7:0] OFS_CNT    = 8'h94;
    localparam logic [7:0] OFS_STAT   = 8'h98;
    localparam logic [7:0] OFS_MASK   = 8'h9c;
    localparam logic [7:0] OFS_DIR    = 8'ha0;

    // Field positions
    localparam int COM_A_LSB  = 6;
    localparam int COM_B_LSB  = 4;
    localparam int WGM_LO_LSB = 0;
    localparam int WGM_HI_LSB = 3;
    localparam int ST_OVF     = 0;
    localparam int ST_MA      = 1;
    localparam int ST_MB      = 2;

    // Writable bits and reset values
    localparam logic [7:0]  CTRL_A_MASK = 8'hf3;
    localparam logic [7:0]  CTRL_B_MASK = 8'hdf;
    localparam logic [7:0]  RST_8       = 8'h00;
    localparam logic [15:0] RST_16      = 16'h0000;
    localparam logic [2:0]  RST_FLAGS   = 3'h0;
    localparam logic [1:0]  RST_DIR     = 2'h0;

    // Counter limits
    localparam logic [15:0] BOTTOM = 16'h0000;
    localparam logic [15:0] TOP_MAX = 16'hffff;
    localparam logic [15:0] TOP_8  = 16'h00ff;
    localparam logic [15:0] TOP_9  = 16'h01ff;
    localparam logic [15:0] TOP_10 = 16'h03ff;

    // Waveform kinds
    localparam logic [1:0] K_NPWM = 2'h0;
    localparam logic [1:0] K_FAST = 2'h1;
    localparam logic [1:0] K_PC   = 2'h2;
    localparam logic [1:0] K_PFC  = 2'h3;

    // Compare-output behaviours
    localparam logic [1:0] COM_OFF = 2'h0;
    localparam logic [1:0] COM_TGL = 2'h1;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* File: hdl/twmc_timer.sv */
// The AXI4-Lite register port was decided locally.
`timescale 1ns/100ps
// Notes on behaviour
// - Everything runs on clk; the timer tick only qualifies counting.
// - Modes 8 and 9 load compare buffers and set overflow at BOTTOM.
// - BOTTOM-set modes mirror the TOP timing around BOTTOM.
// - Channel A field bits 7:6, B bits 5:4; nonzero overrides the port, except a disconnected 01.
// - Pin driver enabled only while its direction bit is set.
// - Non-PWM: 00 off, 01 toggle, 10 clear, 11 set on match.
// - Fast PWM 01 toggles A only in modes 14/15; otherwise disconnected.
// - Fast PWM 10 clears on match, sets at BOTTOM; 11 inverse.
// - Fast PWM: compare equal to TOP ignores match, keeps BOTTOM action.
// - Dual-slope 01 toggles A only in modes 9/11; otherwise disconnected.
// - Dual-slope 10 clears on up match, sets on down match; 11 inverse.
// - Mode is control A bits 1:0 plus two control B bits.
// - Modes 0, 4, 12: TOP fixed/A/capture, immediate update, overflow at MAX.
// - Phase-correct modes load at TOP, overflow at BOTTOM; fixed or register TOP.
// - Fast modes 5-7, 14, 15 load at BOTTOM, overflow at TOP.
// - Mode high bits sit in control B bits 4:3.
// - Capture pin and function disabled while TOP comes from capture.
module twmc_timer (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        timer_tick,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             compare_output_pin_a,
    output logic             compare_output_pin_a_oe,
    output logic             compare_output_pin_a_override,
    output logic             compare_output_pin_b,
    output logic             compare_output_pin_b_oe,
    output logic             compare_output_pin_b_override,
    output logic             capture_enable,
    output logic             irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // Functions

    // Waveform kind of a mode
    function automatic logic [1:0] mode_kind(input logic [3:0] m);
        logic [1:0] k;
        k = twmc_pkg::K_NPWM;
        unique case (m)
            4'h1, 4'h2, 4'h3, 4'ha, 4'hb: k = twmc_pkg::K_PC;
            4'h5, 4'h6, 4'h7, 4'he, 4'hf: k = twmc_pkg::K_FAST;
            4'h8, 4'h9:                   k = twmc_pkg::K_PFC;
            default:                      k = twmc_pkg::K_NPWM;
        endcase
        return k;
    endfunction

    // TOP value of a mode
    function automatic logic [15:0] top_of(input logic [3:0] m, input logic [15:0] ra,
                                           input logic [15:0] ic);
        logic [15:0] t;
        t = twmc_pkg::TOP_MAX;
        unique case (m)
            4'h1, 4'h5:             t = twmc_pkg::TOP_8;
            4'h2, 4'h6:             t = twmc_pkg::TOP_9;
            4'h3, 4'h7:             t = twmc_pkg::TOP_10;
            4'h4, 4'h9, 4'hb, 4'hf: t = ra;
            4'h8, 4'ha, 4'hc, 4'he: t = ic;
            default:                t = twmc_pkg::TOP_MAX;
        endcase
        return t;
    endfunction

    // Whether a channel's waveform owns its pin
    function automatic logic connected(input logic [1:0] k, input logic [1:0] com,
                                       input logic tgl_ok);
        return (com != twmc_pkg::COM_OFF) &&
               (com != twmc_pkg::COM_TGL || k == twmc_pkg::K_NPWM || tgl_ok);
    endfunction

    // Next waveform level of one channel
    function automatic logic wave_next(input logic [1:0] k, input logic [1:0] com,
                                       input logic tgl_ok, input logic m, input logic up,
                                       input logic bev, input logic cur);
        logic v;
        v = cur;
        if (k == twmc_pkg::K_NPWM) begin
            if (m) begin
                v = (com == twmc_pkg::COM_TGL) ? ~cur : com[0];
            end
        end else if (com == twmc_pkg::COM_TGL) begin
            if (m && tgl_ok) begin
                v = ~cur;
            end
        end else if (k == twmc_pkg::K_FAST) begin
            if (bev) begin
                v = ~com[0];
            end else if (m) begin
                v = com[0];
            end
        end else if (m) begin
            v = up ? com[0] : ~com[0];
        end
        return v;
    endfunction

    // Byte-strobed merge into a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] s);
        return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // State

    logic [7:0]  ctrl_a_q;
    logic [7:0]  ctrl_b_q;
    logic [15:0] cmp_a_buf_q;
    logic [15:0] cmp_b_buf_q;
    logic [15:0] cmp_a_q;
    logic [15:0] cmp_b_q;
    logic [15:0] capt_q;
    logic [15:0] cnt_q;
    logic        down_q;
    logic [2:0]  stat_q;
    logic [2:0]  mask_q;
    logic [1:0]  dir_q;
    logic [7:0]  awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Mode decode

    // Mode assembled from both control registers
    wire  [3:0]  mode  = {ctrl_b_q[twmc_pkg::WGM_HI_LSB +: 2],
                          ctrl_a_q[twmc_pkg::WGM_LO_LSB +: 2]};
    wire  [1:0]  kind  = mode_kind(mode);
    wire  [1:0]  com_a = ctrl_a_q[twmc_pkg::COM_A_LSB +: 2];
    wire  [1:0]  com_b = ctrl_a_q[twmc_pkg::COM_B_LSB +: 2];
    wire  [15:0] top   = top_of(mode, cmp_a_q, capt_q);
    wire         dual  = kind[1];
    wire         tgl_a = (kind == twmc_pkg::K_FAST) ? (mode[3:1] == 3'h7)
                                                    : (mode == 4'h9 || mode == 4'hb);
    wire         icr_top = (mode == 4'h8 || mode == 4'ha ||
                            mode == 4'hc || mode == 4'he);

    ////////////////////////////////////////////////////////////////////////////////
    // Counter events, qualified by the tick except the non-PWM buffer load

    wire at_top   = (cnt_q == top);
    wire at_bot   = (cnt_q == twmc_pkg::BOTTOM);
    wire top_evt  = timer_tick && at_top && !down_q;
    wire bot_turn = timer_tick && at_bot && down_q;
    wire max_evt  = timer_tick && (cnt_q == twmc_pkg::TOP_MAX);
    wire match_a  = timer_tick && (cnt_q == cmp_a_q);
    wire match_b  = timer_tick && (cnt_q == cmp_b_q);

    // Overflow flag event per waveform kind
    wire ovf_evt  = (kind == twmc_pkg::K_NPWM) ? max_evt :
                    (kind == twmc_pkg::K_FAST) ? top_evt :
                    bot_turn;

    // Buffer load event per waveform kind
    wire load_evt = (kind == twmc_pkg::K_NPWM) ? 1'b1 :
                    (kind == twmc_pkg::K_FAST) ? top_evt :
                    (kind == twmc_pkg::K_PC)   ? top_evt :
                    bot_turn;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus decode

    wire       wr_en   = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    wire       wr_ca   = wr_en && (awaddr_q == twmc_pkg::OFS_CTRL_A);
    wire       wr_cb   = wr_en && (awaddr_q == twmc_pkg::OFS_CTRL_B);
    wire       wr_ma   = wr_en && (awaddr_q == twmc_pkg::OFS_CMP_A);
    wire       wr_mb   = wr_en && (awaddr_q == twmc_pkg::OFS_CMP_B);
    wire       wr_ic   = wr_en && (awaddr_q == twmc_pkg::OFS_CAPT);
    wire       wr_cn   = wr_en && (awaddr_q == twmc_pkg::OFS_CNT);
    wire       wr_st   = wr_en && (awaddr_q == twmc_pkg::OFS_STAT);
    wire       wr_mk   = wr_en && (awaddr_q == twmc_pkg::OFS_MASK);
    wire       wr_dr   = wr_en && (awaddr_q == twmc_pkg::OFS_DIR);
    wire       wr_hit  = wr_ca || wr_cb || wr_ma || wr_mb || wr_ic ||
                         wr_cn || wr_st || wr_mk || wr_dr;
    wire       byte0   = wstrb_q[0];
    wire [2:0] w1c     = (wr_st && byte0) ? wdata_q[2:0] : 3'h0;
    wire [2:0] set_f   = {match_b, match_a, ovf_evt};
    wire [2:0] stat_d  = (stat_q & ~w1c) | set_f;             // Set wins over clear

    // Read data mux
    wire       rd_hit  = s_axi_araddr[1:0] == 2'h0 && s_axi_araddr >= twmc_pkg::OFS_CTRL_A &&
                         s_axi_araddr <= twmc_pkg::OFS_DIR;
    wire [15:0] rd_lo  =
        (s_axi_araddr == twmc_pkg::OFS_CTRL_A) ? {8'h00, ctrl_a_q}    :
        (s_axi_araddr == twmc_pkg::OFS_CTRL_B) ? {8'h00, ctrl_b_q}    :
        (s_axi_araddr == twmc_pkg::OFS_CMP_A)  ? cmp_a_buf_q          :
        (s_axi_araddr == twmc_pkg::OFS_CMP_B)  ? cmp_b_buf_q          :
        (s_axi_araddr == twmc_pkg::OFS_CAPT)   ? capt_q               :
        (s_axi_araddr == twmc_pkg::OFS_CNT)    ? cnt_q                :
        (s_axi_araddr == twmc_pkg::OFS_STAT)   ? {13'h0000, stat_q}   :
        (s_axi_araddr == twmc_pkg::OFS_MASK)   ? {13'h0000, mask_q}   :
        (s_axi_araddr == twmc_pkg::OFS_DIR)    ? {14'h0000, dir_q}    : 16'h0000;

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel

    // Capture address and data in either order, answer once both held
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= twmc_pkg::RESP_OKAY;
            awaddr_q      <= 8'h00;
            wdata_q       <= 32'h0000_0000;
            wstrb_q       <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                awaddr_q      <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                wdata_q      <= s_axi_wdata;
                wstrb_q      <= s_axi_wstrb;
            end
            if (wr_en) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? twmc_pkg::RESP_OKAY : twmc_pkg::RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel

    // One-cycle read answer, error if unmapped
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= twmc_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= {16'h0000, rd_lo};
            s_axi_rresp   <= rd_hit ? twmc_pkg::RESP_OKAY : twmc_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Software registers

    // Control, buffers, capture value, mask and direction
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ctrl_a_q    <= twmc_pkg::RST_8;
            ctrl_b_q    <= twmc_pkg::RST_8;
            cmp_a_buf_q <= twmc_pkg::RST_16;
            cmp_b_buf_q <= twmc_pkg::RST_16;
            capt_q      <= twmc_pkg::RST_16;
            mask_q      <= twmc_pkg::RST_FLAGS;
            dir_q       <= twmc_pkg::RST_DIR;
        end else begin
            if (wr_ca && byte0) begin
                ctrl_a_q <= wdata_q[7:0] & twmc_pkg::CTRL_A_MASK;
            end
            if (wr_cb && byte0) begin
                ctrl_b_q <= wdata_q[7:0] & twmc_pkg::CTRL_B_MASK;
            end
            if (wr_ma) begin
                cmp_a_buf_q <= merge16(cmp_a_buf_q, wdata_q, wstrb_q);
            end
            if (wr_mb) begin
                cmp_b_buf_q <= merge16(cmp_b_buf_q, wdata_q, wstrb_q);
            end
            if (wr_ic) begin
                capt_q <= merge16(capt_q, wdata_q, wstrb_q);
            end
            if (wr_mk && byte0) begin
                mask_q <= wdata_q[2:0];
            end
            if (wr_dr && byte0) begin
                dir_q <= wdata_q[1:0];
            end
        end
    end

    // Active compare values follow the buffers at the load event
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cmp_a_q <= twmc_pkg::RST_16;
            cmp_b_q <= twmc_pkg::RST_16;
        end else if (load_evt) begin
            cmp_a_q <= cmp_a_buf_q;
            cmp_b_q <= cmp_b_buf_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Counter

    // Single slope wraps at TOP, dual slope turns at TOP and BOTTOM
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cnt_q  <= twmc_pkg::RST_16;
            down_q <= 1'b0;
        end else if (wr_cn) begin
            cnt_q <= merge16(cnt_q, wdata_q, wstrb_q);
        end else if (timer_tick) begin
            if (!dual) begin
                cnt_q  <= at_top ? twmc_pkg::BOTTOM : cnt_q + 16'h0001;
                down_q <= 1'b0;
            end else if (!down_q) begin
                down_q <= (cnt_q >= top);
                cnt_q  <= (cnt_q >= top) ? cnt_q - 16'h0001 : cnt_q + 16'h0001;
            end else begin
                down_q <= !at_bot;
                cnt_q  <= at_bot ? cnt_q + 16'h0001 : cnt_q - 16'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Flags and interrupt

    // Sticky flags, write one to clear, mask gates the interrupt
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            stat_q <= twmc_pkg::RST_FLAGS;
            irq    <= 1'b0;
        end else begin
            stat_q <= stat_d;
            irq    <= |(stat_q & mask_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Waveform outputs

    wire conn_a = connected(kind, com_a, tgl_a);
    wire conn_b = connected(kind, com_b, 1'b0);
    wire next_a = wave_next(kind, com_a, tgl_a, match_a, !down_q, top_evt,
                            compare_output_pin_a);
    wire next_b = wave_next(kind, com_b, 1'b0, match_b, !down_q, top_evt,
                            compare_output_pin_b);

    // Waveform levels, pin override and driver enable
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            compare_output_pin_a          <= 1'b0;
            compare_output_pin_b          <= 1'b0;
            compare_output_pin_a_override <= 1'b0;
            compare_output_pin_b_override <= 1'b0;
            compare_output_pin_a_oe       <= 1'b0;
            compare_output_pin_b_oe       <= 1'b0;
            capture_enable                <= 1'b1;
        end else begin
            compare_output_pin_a          <= conn_a ? next_a : compare_output_pin_a;
            compare_output_pin_b          <= conn_b ? next_b : compare_output_pin_b;
            compare_output_pin_a_override <= conn_a;
            compare_output_pin_b_override <= conn_b;
            compare_output_pin_a_oe       <= conn_a && dir_q[0];
            compare_output_pin_b_oe       <= conn_b && dir_q[1];
            capture_enable                <= !icr_top;
        end
    end

endmodule

/* File: test/twmc_timer_properties.sv */
`timescale 1ns/100ps
module twmc_timer_properties (
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        compare_output_pin_a_oe,
    input wire logic        compare_output_pin_a_override,
    input wire logic        compare_output_pin_b_oe,
    input wire logic        compare_output_pin_b_override,
    input wire logic        capture_enable
);
    logic [7:0] aw_q, wd_q, ctla_q, ctlb_q;
    logic [1:0] dir_q, cnt_q;
    logic       bv_q, tgl_a, tgl_b, ovr_a, ovr_b, settled;
    logic [3:0] mode;

    // Expected pin ownership
    assign mode    = {ctlb_q[4:3], ctla_q[1:0]};
    assign tgl_a   = mode inside {4'h0, 4'h4, 4'hc, 4'hd, 4'h9, 4'hb, 4'he, 4'hf};
    assign tgl_b   = mode inside {4'h0, 4'h4, 4'hc, 4'hd};
    assign ovr_a   = ctla_q[7:6] != 2'h0 && (ctla_q[7:6] != 2'h1 || tgl_a);
    assign ovr_b   = ctla_q[5:4] != 2'h0 && (ctla_q[5:4] != 2'h1 || tgl_b);
    assign settled = cnt_q == 2'h3 && mode != 4'hd;

    // Shadow of committed writes, quiet count
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            {aw_q, wd_q, ctla_q, ctlb_q, dir_q, cnt_q, bv_q} <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready)
                aw_q <= s_axi_awaddr;
            if (s_axi_wvalid && s_axi_wready)
                wd_q <= s_axi_wdata[7:0];
            if (s_axi_bvalid && !bv_q && aw_q == 8'h80)
                ctla_q <= wd_q & twmc_pkg::CTRL_A_MASK;
            if (s_axi_bvalid && !bv_q && aw_q == 8'h84)
                ctlb_q <= wd_q;
            if (s_axi_bvalid && !bv_q && aw_q == 8'ha0)
                dir_q <= wd_q[1:0];
            bv_q  <= s_axi_bvalid;
            cnt_q <= s_axi_bvalid ? 2'h0 : (cnt_q == 2'h3 ? cnt_q : cnt_q + 2'h1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking dcb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    property p_oe_a; settled |-> compare_output_pin_a_oe == (ovr_a && dir_q[0]); endproperty
    a_oe_a: assert property (p_oe_a) else $error("pin a enable wrong");
    property p_oe_b; settled |-> compare_output_pin_b_oe == (ovr_b && dir_q[1]); endproperty
    a_oe_b: assert property (p_oe_b) else $error("pin b enable wrong");
    property p_ovr_a; settled |-> compare_output_pin_a_override == ovr_a; endproperty
    a_ovr_a: assert property (p_ovr_a) else $error("pin a override wrong");
    property p_ovr_b; settled |-> compare_output_pin_b_override == ovr_b; endproperty
    a_ovr_b: assert property (p_ovr_b) else $error("pin b override wrong");
    property p_capt; settled |-> capture_enable == !(mode inside {8, 10, 12, 14}); endproperty
    a_capt: assert property (p_capt) else $error("capture enable wrong");
    property p_wr_ans; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid; endproperty
    a_wr_ans: assert property (p_wr_ans) else $error("write response late");
    property p_rd_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read response late");
    property p_aw_busy; s_axi_awvalid && s_axi_awready |=> !s_axi_awready; endproperty
    a_aw_busy: assert property (p_aw_busy) else $error("write address taken twice");
    property p_ar_busy; s_axi_arvalid && s_axi_arready |=> !s_axi_arready; endproperty
    a_ar_busy: assert property (p_ar_busy) else $error("read address taken twice");

    c_drive: cover property (settled && compare_output_pin_a_oe);
    c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
    c_capt: cover property (settled && !capture_enable);
endmodule

bind twmc_timer twmc_timer_properties u_props (.clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .compare_output_pin_a_oe,
    .compare_output_pin_a_override, .compare_output_pin_b_oe, .compare_output_pin_b_override,
    .capture_enable);

/* File: test/twmc_timer_tb.sv */
`timescale 1ns/100ps
module twmc_timer_tb;
    logic        clk = 1'h0, rst_b = 1'h0, timer_tick = 1'h0, p;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, a;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d, msk;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
    logic        s_axi_bready = 1'h1, s_axi_rready = 1'h1;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        pin_a, oe_a, ovr_a, pin_b, oe_b, ovr_b, capture_enable, irq;
    logic [33:0] exp_q[$];
    int          miscompares = 0, checks = 0;

    twmc_timer dut (.clk, .rst_b, .timer_tick, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .compare_output_pin_a(pin_a),
        .compare_output_pin_a_oe(oe_a), .compare_output_pin_a_override(ovr_a),
        .compare_output_pin_b(pin_b), .compare_output_pin_b_oe(oe_b),
        .compare_output_pin_b_override(ovr_b), .capture_enable, .irq);

    // Free-running clock
    always #2 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [33:0] got, input logic [33:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_sim;
        $display("miscompares %0d checks %0d", miscompares, checks);
        if (miscompares == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Write, response noted
    task automatic wr(input logic [7:0] ad, input logic [31:0] dt, input logic [1:0] r = 2'h0);
        logic aw_ok = 1'h0, w_ok = 1'h0;
        exp_q.push_back({r, 32'h0});
        s_axi_awaddr <= ad;
        s_axi_wdata <= dt;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        do begin
            @(posedge clk);
            aw_ok |= s_axi_awvalid && s_axi_awready;
            w_ok |= s_axi_wvalid && s_axi_wready;
            s_axi_awvalid <= s_axi_awvalid && !s_axi_awready;
            s_axi_wvalid <= s_axi_wvalid && !s_axi_wready;
        end while (!(aw_ok && w_ok));
        do @(posedge clk); while (!s_axi_bvalid);
    endtask

    // Read, data and response noted
    task automatic rd(input logic [7:0] ad, input logic [31:0] e, input logic [1:0] r = 2'h0);
        exp_q.push_back({r, e});
        s_axi_araddr <= ad;
        s_axi_arvalid <= 1'h1;
        do @(posedge clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        do @(posedge clk); while (!s_axi_rvalid);
    endtask

    // Bus results against the oldest note
    always @(posedge clk) begin
        if ((s_axi_rvalid || s_axi_bvalid) && exp_q.size() == 0)
            miscompares++;
        else if (s_axi_rvalid)
            check({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
        else if (s_axi_bvalid)
            check({s_axi_bresp, 32'h0}, exp_q.pop_front());
    end

    // Watchdog
    initial begin
        #200000;
        miscompares++;
        end_sim;
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h7fa7));
        repeat (4) @(posedge clk);
        rst_b <= 1'h1;
        @(posedge clk);
        for (int i = 0; i < 9; i++)
            rd(8'h80 + 8'(4 * i), 32'h0);
        rd(8'h00, 32'h0, twmc_pkg::RESP_SLVERR);
        wr(8'h00, 32'h0, twmc_pkg::RESP_SLVERR);
        // Random values read back
        for (int i = 0; i < 20; i++) begin
            d = $urandom;
            a = 8'h80 + 8'(4 * (i % 5));
            msk = a == 8'h80 ? {24'h0, twmc_pkg::CTRL_A_MASK} : 32'hffff;
            msk = a == 8'h84 ? {24'h0, twmc_pkg::CTRL_B_MASK} : msk;
            wr(a, d);
            rd(a, d & msk);
        end
        // Every mode except 13, every output pair
        for (int m = 0; m < 16; m++)
            for (int c = 0; c < 16; c++) begin
                if (m == 13)
                    continue;
                wr(8'h80, {24'h0, 4'(c), 2'h0, 2'(m)});
                wr(8'h84, {27'h0, 2'(m >> 2), 3'h0});
                wr(8'ha0, $urandom % 4);
                repeat (4) @(posedge clk);
                check(capture_enable, !(m inside {8, 10, 12, 14}));
            end
        // Clear on match: set, clear, toggle
        wr(8'h88, 32'h3);
        wr(8'h94, 32'h0);
        wr(8'ha0, 32'h1);
        wr(8'h84, 32'h08);
        wr(8'h80, 32'hc0);
        timer_tick <= 1'h1;
        repeat (12) @(posedge clk);
        check(pin_a, 1'h1);
        check(oe_a, 1'h1);
        wr(8'h80, 32'h80);
        repeat (12) @(posedge clk);
        check(pin_a, 1'h0);
        wr(8'h80, 32'h40);
        repeat (8) @(posedge clk);
        p = pin_a;
        repeat (4) @(posedge clk);
        check(pin_a, !p);
        timer_tick <= 1'h0;
        // Fast PWM: wrap sets pin and overflow, match clears
        wr(8'h80, 32'h81);
        wr(8'h8c, 32'h8000);
        wr(8'h88, 32'h10);
        wr(8'h98, 32'h7);
        wr(8'h9c, 32'h1);
        wr(8'h94, 32'hfe);
        timer_tick <= 1'h1;
        repeat (2) @(posedge clk);
        timer_tick <= 1'h0;
        repeat (2) @(posedge clk);
        check(pin_a, 1'h1);
        check(irq, 1'h1);
        rd(8'h98, 32'h1);
        wr(8'h98, 32'h1);
        rd(8'h98, 32'h0);
        check(irq, 1'h0);
        timer_tick <= 1'h1;
        repeat (17) @(posedge clk);
        timer_tick <= 1'h0;
        repeat (2) @(posedge clk);
        check(pin_a, 1'h0);
        rd(8'h98, 32'h2);
        // Phase correct: down-count match sets pin
        wr(8'h84, 32'h0);
        timer_tick <= 1'h1;
        repeat (490) @(posedge clk);
        timer_tick <= 1'h0;
        repeat (2) @(posedge clk);
        check(pin_a, 1'h1);
        end_sim;
    end
endmodule
